// ==== rtl/sdc_pkg.sv ====
// constants and types shared by the command, refresh and access block
package sdc_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TRAS_PS = 45000;
  localparam int TRTP_PS = 7500;
  localparam int TREFI_PS = 7800000;
  // least times round up, the refresh interval is a longest time and rounds down
  localparam int TRAS_CK = (TRAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRTP_CK = (TRTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TREFI_CK = TREFI_PS / CLK_PERIOD_PS;

  localparam int BANKS = 8;
  localparam int COL_W = 10;
  localparam int ROW_W = 14;
  localparam int AP_W = 6;
  localparam int HIST_DEPTH = 16;
  localparam int TMR_W = 12;

  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_REFROW = 4'h8;
  localparam logic [3:0] OFS_REFCNT = 4'hc;

  localparam int CFG_CL_LSB = 0;
  localparam int CFG_AL_LSB = 4;
  localparam int CFG_BL8_BIT = 8;
  localparam int CFG_ILV_BIT = 9;
  localparam int CFG_WR_LSB = 12;
  localparam int ST_SREF_BIT = 8;
  localparam int ST_DLL_BIT = 9;
  localparam int ST_CLK_BIT = 10;

  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [3:0] WR_RST = 4'h3;
  localparam logic BL8_RST = 1'b0;
  localparam logic ILV_RST = 1'b0;

  // {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_UND = 3'h6,
    CMD_NOP = 3'h7
  } sdc_cmd_type;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SREF = 2'h1
  } sdc_pwr_type;
endpackage

// ==== rtl/sdc_ap_timer.sv ====
// per-bank auto-precharge countdown gated by the row active time
`timescale 1ns/100ps
module sdc_ap_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic [sdc_pkg::AP_W-1:0] load_val,
  input wire logic activate,
  input wire logic clear,
  output logic fire
);
  logic [sdc_pkg::AP_W-1:0] cnt_q, cnt_d;
  logic [sdc_pkg::AP_W-1:0] ras_q, ras_d;
  logic armed_q, armed_d;
  logic ras_ok;
  logic [sdc_pkg::AP_W-1:0] elapsed_q, need_q;

  assign ras_ok = ras_q >= sdc_pkg::AP_W'(sdc_pkg::TRAS_CK);

  always_comb begin
    ras_d = ras_q;
    if (activate) begin
      ras_d = '0;
    end else if (!ras_ok) begin
      ras_d = ras_q + 1'b1;
    end
    cnt_d = cnt_q;
    armed_d = armed_q;
    if (clear) begin
      armed_d = 1'b0;
    end else if (load) begin
      // counted so that the precharge lands on the edge load_val after the command
      armed_d = 1'b1;
      cnt_d = load_val - 1'b1;
    end else if (armed_q) begin
      if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;
      end else if (ras_ok) begin
        armed_d = 1'b0;
      end
    end
  end

  // [RL1] wait for delay and tras
  assign fire = armed_q && (cnt_q == '0) && ras_ok && !clear && !load;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      ras_q <= '0;
      armed_q <= 1'b0;
      elapsed_q <= '0;
      need_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      ras_q <= ras_d;
      armed_q <= armed_d;
      elapsed_q <= load ? '0 : ((elapsed_q == '1) ? elapsed_q : elapsed_q + 1'b1);
      need_q <= load ? load_val : need_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ap_not_early: assert property (fire |-> elapsed_q >= need_q - 1'b1) // [RL2]
    else $error("auto precharge fired before its delay");
  chk_ap_tras_hold: assert property (armed_q && !ras_ok |-> !fire) // [RL1]
    else $error("auto precharge fired before row active time");
endmodule // sdc_ap_timer

// ==== rtl/sdc_burst_col.sv ====
// column of a burst beat, kept inside its aligned segment
`timescale 1ns/100ps
module sdc_burst_col (
  input wire logic [sdc_pkg::COL_W-1:0] start_col,
  input wire logic [2:0] idx,
  input wire logic bl8,
  input wire logic interleave,
  output logic [sdc_pkg::COL_W-1:0] col
);
  logic [2:0] low;

  // [RL18] stay within segment
  always_comb begin
    if (interleave) begin
      low = start_col[2:0] ^ idx;
    end else begin
      // sequential order wraps per nibble
      low = {start_col[2] ^ idx[2], 2'(start_col[1:0] + idx[1:0])};
    end
    if (!bl8) begin
      low[2] = start_col[2];
    end
    col = {start_col[sdc_pkg::COL_W-1:3], low};
  end
endmodule // sdc_burst_col

// ==== rtl/sdc_top.sv ====
// command decode, auto precharge, refresh, self refresh and posted column timing
`timescale 1ns/100ps
// Function
// [RL1] read autoprecharge at AL+BL/2, tRAS/tRTP met
// [RL2] write autoprecharge after burst plus recovery
// [RL3] precharge all closes every bank
// [RL4] enter self refresh, stay while CKE low
// [RL5] internal refresh timer, DLL off then on
// [RL6] self refresh ignores inputs, clock gated
// [RL7] controller turns termination off first
// [RL8] controller may stop clock after entry
// [RL9] controller waits tXSNR after exit
// [RL10] controller sends NOP during tXSNR
// [RL11] controller holds CKE high during tXSRD
// [RL12] controller refreshes once before re-entry
// [RL13] refresh row generated internally, address ignored
// [RL14] controller keeps average refresh within tREFI
// [RL15] refresh leaves banks idle; tRFC by controller
// [RL16] controller posts at most eight refreshes
// [RL17] deselect and NOP do nothing
// [RL18] burst stays inside its aligned segment
// [RL19] controller interrupts only BL8 same kind
// [RL20] controller spaces column commands by tCCD
// [RL21] column command issued internally after AL
// [RL22] read latency AL+CL, write one less
// [RL23] controller sets nonzero AL before tRCD
// [RL24] additive latency zero to six
// [RL25] decode on rising edge with CKE high
module sdc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [sdc_pkg::ROW_W-1:0] addr,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [sdc_pkg::BANKS-1:0] bank_open_q,
  output logic self_refresh_q,
  output logic dll_on_q,
  output logic clk_run_q,
  output logic int_rd_q,
  output logic int_wr_q,
  output logic [sdc_pkg::COL_W-1:0] int_col_q,
  output logic rd_data_q,
  output logic wr_data_q,
  output logic [sdc_pkg::COL_W-1:0] beat_col_q,
  output logic [sdc_pkg::ROW_W-1:0] ref_row_q
);
  sdc_pkg::sdc_cmd_type cmd;
  sdc_pkg::sdc_pwr_type pwr_q, pwr_d;
  logic cke_prev_q;
  logic sel, dec_ok, is_act, is_rd, is_wr, is_pre, is_ref, is_sre, pall, pre_one, is_exit;
  logic [2:0] cl_q, cl_d, al_q, al_d;
  logic bl8_q, bl8_d, ilv_q, ilv_d;
  logic [3:0] wrec_q, wrec_d;
  logic [sdc_pkg::BANKS-1:0] bank_d, ap_fire;
  logic [sdc_pkg::AP_W-1:0] bl_half, rd_ap, wr_ap, trtp;
  logic [sdc_pkg::TMR_W-1:0] sr_tmr_q, sr_tmr_d;
  logic [sdc_pkg::ROW_W-1:0] ref_row_d;
  logic [15:0] ref_cnt_q, ref_cnt_d;
  logic [sdc_pkg::HIST_DEPTH-1:0] hv_q, hv_d, hrd_q, hrd_d;
  logic [sdc_pkg::COL_W-1:0] hcol_q [sdc_pkg::HIST_DEPTH];
  logic [sdc_pkg::COL_W-1:0] hcol_d [sdc_pkg::HIST_DEPTH];
  logic [3:0] al_idx, rl_idx, wl_idx;
  logic start_rd, start_wr, act_q, act_d, brd_q, brd_d;
  logic [1:0] left_q, left_d;
  logic [2:0] idx_q, idx_d;
  logic [sdc_pkg::COL_W-1:0] bcol_q, bcol_d, beat_col_d;
  logic wait_d, req, wr_commit;
  logic [31:0] rdata_d, rd_mux;

  assign cmd = sdc_pkg::sdc_cmd_type'({ras_n, cas_n, we_n});

  // [RL6] no command decoded in self refresh; cs_n and the code only matter for exit with cke high
  assign sel = (pwr_q == sdc_pkg::PWR_ACTIVE) && cke_prev_q && !cs_n;
  // [RL25] decode only with cke high
  assign dec_ok = sel && cke;
  // [RL17] deselect, no-op and undefined codes match none of these
  assign is_act = dec_ok && (cmd == sdc_pkg::CMD_ACT);
  assign is_rd = dec_ok && (cmd == sdc_pkg::CMD_RD);
  assign is_wr = dec_ok && (cmd == sdc_pkg::CMD_WR);
  assign is_pre = dec_ok && (cmd == sdc_pkg::CMD_PRE);
  assign is_ref = dec_ok && (cmd == sdc_pkg::CMD_REF);
  // [RL4] self refresh entry samples cke low
  assign is_sre = sel && !cke && (cmd == sdc_pkg::CMD_REF);
  assign pall = is_pre && addr[10];
  assign pre_one = is_pre && !addr[10];
  assign is_exit = cke && (cs_n || (cmd == sdc_pkg::CMD_NOP));

  // [RL4] power state machine
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      sdc_pkg::PWR_ACTIVE: begin
        if (is_sre) begin
          pwr_d = sdc_pkg::PWR_SREF;
        end
      end
      sdc_pkg::PWR_SREF: begin
        if (is_exit) begin
          pwr_d = sdc_pkg::PWR_ACTIVE;
        end
      end
      default: begin
        pwr_d = sdc_pkg::PWR_ACTIVE;
      end
    endcase
  end

  // [RL5] internal refresh timer while no clock is expected
  always_comb begin
    sr_tmr_d = '0;
    ref_row_d = ref_row_q;
    ref_cnt_d = ref_cnt_q;
    if (pwr_q == sdc_pkg::PWR_SREF) begin
      sr_tmr_d = sr_tmr_q + 1'b1;
      if (sr_tmr_q == sdc_pkg::TMR_W'(sdc_pkg::TREFI_CK - 1)) begin
        sr_tmr_d = '0;
        ref_row_d = ref_row_q + 1'b1;
        ref_cnt_d = ref_cnt_q + 1'b1;
      end
    end else if (is_ref) begin
      // [RL13] row from internal counter
      ref_row_d = ref_row_q + 1'b1;
      ref_cnt_d = ref_cnt_q + 1'b1;
    end
  end

  assign bl_half = bl8_q ? sdc_pkg::AP_W'(4) : sdc_pkg::AP_W'(2);
  assign trtp = sdc_pkg::AP_W'(sdc_pkg::TRTP_CK);
  // [RL1] read delay, at least trtp after internal issue
  assign rd_ap = sdc_pkg::AP_W'(al_q) + ((bl_half > trtp) ? bl_half : trtp);
  // [RL2] write latency plus burst plus recovery
  assign wr_ap = sdc_pkg::AP_W'(al_q) + sdc_pkg::AP_W'(cl_q) - 1'b1 + bl_half + sdc_pkg::AP_W'(wrec_q);

  genvar b;
  generate
    for (b = 0; b < sdc_pkg::BANKS; b++) begin : g_bank
      sdc_ap_timer u_tmr (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .load((is_rd || is_wr) && addr[10] && (ba == 3'(b))),
        .load_val(is_rd ? rd_ap : wr_ap),
        .activate(is_act && (ba == 3'(b))),
        .clear(pall || is_ref || (pre_one && (ba == 3'(b)))),
        .fire(ap_fire[b])
      );
    end
  endgenerate

  always_comb begin
    bank_d = bank_open_q & ~ap_fire;
    // [RL3] precharge all, [RL15] refresh leaves banks idle
    if (pall || is_ref) begin
      bank_d = '0;
    end
    if (pre_one) begin
      bank_d[ba] = 1'b0;
    end
    if (is_act) begin
      bank_d[ba] = 1'b1;
    end
  end

  // [RL21] column commands held in a history line until issue
  always_comb begin
    hv_d = {hv_q[sdc_pkg::HIST_DEPTH-2:0], is_rd || is_wr};
    hrd_d = {hrd_q[sdc_pkg::HIST_DEPTH-2:0], is_rd};
    hcol_d[0] = addr[sdc_pkg::COL_W-1:0];
    for (int i = 1; i < sdc_pkg::HIST_DEPTH; i++) begin
      hcol_d[i] = hcol_q[i-1];
    end
  end

  assign al_idx = {1'b0, al_q};
  // [RL22] read latency al plus cl, write one less
  assign rl_idx = {1'b0, al_q} + {1'b0, cl_q};
  assign wl_idx = rl_idx - 1'b1;
  assign start_rd = hv_q[rl_idx] && hrd_q[rl_idx];
  assign start_wr = hv_q[wl_idx] && !hrd_q[wl_idx];

  // two beats per clock; a new start simply restarts the burst
  always_comb begin
    act_d = act_q;
    brd_d = brd_q;
    left_d = left_q;
    idx_d = idx_q;
    bcol_d = bcol_q;
    if (start_rd || start_wr) begin
      act_d = 1'b1;
      brd_d = start_rd;
      left_d = bl8_q ? 2'h3 : 2'h1;
      idx_d = 3'h0;
      bcol_d = start_rd ? hcol_q[rl_idx] : hcol_q[wl_idx];
    end else if (act_q) begin
      idx_d = idx_q + 3'h2;
      if (left_q == 2'h0) begin
        act_d = 1'b0;
      end else begin
        left_d = left_q - 1'b1;
      end
    end
  end

  sdc_burst_col u_col (
    .start_col(bcol_d),
    .idx(idx_d),
    .bl8(bl8_q),
    .interleave(ilv_q),
    .col(beat_col_d)
  );

  // register slave: one wait cycle then a single-cycle answer
  assign req = avs_read || avs_write;
  assign wait_d = !(req && avs_waitrequest);
  assign wr_commit = avs_write && !avs_waitrequest;

  always_comb begin
    if (avs_address == sdc_pkg::OFS_CFG) begin
      rd_mux = '0;
      rd_mux[sdc_pkg::CFG_CL_LSB +: 3] = cl_q;
      rd_mux[sdc_pkg::CFG_AL_LSB +: 3] = al_q;
      rd_mux[sdc_pkg::CFG_BL8_BIT] = bl8_q;
      rd_mux[sdc_pkg::CFG_ILV_BIT] = ilv_q;
      rd_mux[sdc_pkg::CFG_WR_LSB +: 4] = wrec_q;
    end else if (avs_address == sdc_pkg::OFS_STATUS) begin
      rd_mux = '0;
      rd_mux[sdc_pkg::BANKS-1:0] = bank_open_q;
      rd_mux[sdc_pkg::ST_SREF_BIT] = self_refresh_q;
      rd_mux[sdc_pkg::ST_DLL_BIT] = dll_on_q;
      rd_mux[sdc_pkg::ST_CLK_BIT] = clk_run_q;
    end else if (avs_address == sdc_pkg::OFS_REFROW) begin
      rd_mux = {18'h0, ref_row_q};
    end else if (avs_address == sdc_pkg::OFS_REFCNT) begin
      rd_mux = {16'h0, ref_cnt_q};
    end else begin
      rd_mux = '0;
    end
    rdata_d = (avs_read && avs_waitrequest) ? rd_mux : avs_readdata;
  end

  // config changes take hold for later commands; bursts in flight see new values
  always_comb begin
    cl_d = cl_q;
    al_d = al_q;
    bl8_d = bl8_q;
    ilv_d = ilv_q;
    wrec_d = wrec_q;
    if (wr_commit && (avs_address == sdc_pkg::OFS_CFG)) begin
      if (avs_byteenable[0]) begin
        cl_d = avs_writedata[sdc_pkg::CFG_CL_LSB +: 3];
        // [RL24] additive latency limited to six
        al_d = (avs_writedata[sdc_pkg::CFG_AL_LSB +: 3] > sdc_pkg::AL_MAX) ? sdc_pkg::AL_MAX :
          avs_writedata[sdc_pkg::CFG_AL_LSB +: 3];
      end
      if (avs_byteenable[1]) begin
        bl8_d = avs_writedata[sdc_pkg::CFG_BL8_BIT];
        ilv_d = avs_writedata[sdc_pkg::CFG_ILV_BIT];
        wrec_d = avs_writedata[sdc_pkg::CFG_WR_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= sdc_pkg::PWR_ACTIVE;
      cke_prev_q <= 1'b0;
      self_refresh_q <= 1'b0;
      dll_on_q <= 1'b1;
      clk_run_q <= 1'b1;
      sr_tmr_q <= '0;
      ref_row_q <= '0;
      ref_cnt_q <= '0;
      bank_open_q <= '0;
      hv_q <= '0;
      hrd_q <= '0;
      for (int i = 0; i < sdc_pkg::HIST_DEPTH; i++) begin
        hcol_q[i] <= '0;
      end
      int_rd_q <= 1'b0;
      int_wr_q <= 1'b0;
      int_col_q <= '0;
      act_q <= 1'b0;
      brd_q <= 1'b0;
      left_q <= '0;
      idx_q <= '0;
      bcol_q <= '0;
      rd_data_q <= 1'b0;
      wr_data_q <= 1'b0;
      beat_col_q <= '0;
      cl_q <= sdc_pkg::CL_RST;
      al_q <= sdc_pkg::AL_RST;
      bl8_q <= sdc_pkg::BL8_RST;
      ilv_q <= sdc_pkg::ILV_RST;
      wrec_q <= sdc_pkg::WR_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if (ce) begin
      pwr_q <= pwr_d;
      cke_prev_q <= cke;
      // [RL5] dll and clock follow the power state
      self_refresh_q <= (pwr_d == sdc_pkg::PWR_SREF);
      dll_on_q <= (pwr_d != sdc_pkg::PWR_SREF);
      clk_run_q <= (pwr_d != sdc_pkg::PWR_SREF);
      sr_tmr_q <= sr_tmr_d;
      ref_row_q <= ref_row_d;
      ref_cnt_q <= ref_cnt_d;
      bank_open_q <= bank_d;
      hv_q <= hv_d;
      hrd_q <= hrd_d;
      hcol_q <= hcol_d;
      // [RL21] issue after the additive latency
      int_rd_q <= hv_q[al_idx] && hrd_q[al_idx];
      int_wr_q <= hv_q[al_idx] && !hrd_q[al_idx];
      int_col_q <= hcol_q[al_idx];
      act_q <= act_d;
      brd_q <= brd_d;
      left_q <= left_d;
      idx_q <= idx_d;
      bcol_q <= bcol_d;
      rd_data_q <= act_d && brd_d;
      wr_data_q <= act_d && !brd_d;
      beat_col_q <= beat_col_d;
      cl_q <= cl_d;
      al_q <= al_d;
      bl8_q <= bl8_d;
      ilv_q <= ilv_d;
      wrec_q <= wrec_d;
      avs_waitrequest <= wait_d;
      avs_readdata <= rdata_d;
    end
  end

  // helper: cycles since the last column command and the gap before it
  logic [4:0] since_q, gap_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_q <= '1;
      gap_q <= '0;
    end else if (ce) begin
      since_q <= (is_rd || is_wr) ? '0 : ((since_q == '1) ? since_q : since_q + 1'b1);
      gap_q <= (is_rd || is_wr) ? since_q : gap_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_pall_idle: assert property (ce && pall && !is_act |=> bank_open_q == '0) // [RL3]
    else $error("banks open after precharge all");
  chk_sref_entry: assert property (ce && is_sre |=> self_refresh_q && !dll_on_q && !clk_run_q) // [RL5]
    else $error("self refresh entry did not stop dll and clock");
  chk_sref_frozen: assert property (self_refresh_q && ce && !cke |=> $stable(hv_q) && self_refresh_q) // [RL6]
    else $error("input accepted during self refresh");
  chk_ref_row: assert property (ce && is_ref |=> ref_row_q == $past(ref_row_q) + 1'b1 && bank_open_q == '0) // [RL13]
    else $error("refresh row not advanced or banks left open");
  chk_desel_none: assert property (ce && (cs_n || !cke) && !is_sre |=> !hv_q[0]) // [RL17]
    else $error("column command taken while deselected");
  chk_issue_al: assert property ($rose(int_rd_q) && gap_q > 5'd15 && since_q < 5'd15 |-> since_q == 5'(al_q) + 5'd1) // [RL21]
    else $error("internal read not delayed by additive latency");
  chk_read_lat: assert property ($rose(rd_data_q) && gap_q > 5'd15 && since_q < 5'd20 |-> since_q == 5'(rl_idx) + 5'd1) // [RL22]
    else $error("read data window not at read latency");
  chk_beat_seg: assert property (rd_data_q || wr_data_q |-> beat_col_q[sdc_pkg::COL_W-1:3] == bcol_q[sdc_pkg::COL_W-1:3]) // [RL18]
    else $error("burst left its segment");
  chk_al_range: assert property (al_q <= sdc_pkg::AL_MAX) // [RL24]
    else $error("additive latency above six");

  cov_sref: cover property ($fell(self_refresh_q));
  cov_ap_fire: cover property (|ap_fire);
  cov_bl8_read: cover property (bl8_q && $rose(rd_data_q));
endmodule // sdc_top

// ==== tb/sdc_ctrl_model.sv ====
// behavioural memory controller driving the command pins
`timescale 1ns/100ps
module sdc_ctrl_model (
  input wire logic clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [sdc_pkg::ROW_W-1:0] addr
);
  logic cke_v = 1'b1;
  initial begin
    // cke high from the start, so the first command after reset is not lost
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = '0;
  end
  // deselect, cke held
  // junk on the ignored pins, so a decoder that looks at them shows it
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      cke <= cke_v;
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'($urandom);
      ba <= 3'($urandom);
      addr <= 14'($urandom);
    end
  endtask
  // callers space commands, no burst interrupted
  task automatic issue(input logic [2:0] code, input logic [2:0] b, input logic [13:0] a, input logic k);
    @(posedge clk);
    cke <= k;
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= code;
    ba <= b;
    addr <= a;
    cke_v = k;
    idle(1);
  endtask
endmodule // sdc_ctrl_model

// ==== tb/test_sdc_top.sv ====
// self-checking bench for the command, refresh and access block
`timescale 1ns/100ps
module test_sdc_top;
  logic clk, nrst, ce, cke, cs_n, ras_n, cas_n, we_n, avs_read, avs_write, avs_waitrequest;
  logic self_refresh_q, dll_on_q, clk_run_q, int_rd_q, int_wr_q, rd_data_q, wr_data_q, p_int, p_dat;
  logic [2:0] ba;
  logic [3:0] avs_address, avs_byteenable, be_w;
  logic [13:0] addr, ref_row_q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] bank_open_q;
  logic [9:0] int_col_q, beat_col_q, seg;
  logic [31:0] q_reg[$], q_int[$], q_col[$], q_dat[$];
  int cyc, err_total, n_compared, al, cl, c0, sh, nref;
  sdc_top sdc_top_i (.clk(clk), .nrst(nrst), .ce(ce), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bank_open_q(bank_open_q), .self_refresh_q(self_refresh_q),
    .dll_on_q(dll_on_q), .clk_run_q(clk_run_q), .int_rd_q(int_rd_q), .int_wr_q(int_wr_q), .int_col_q(int_col_q),
    .rd_data_q(rd_data_q), .wr_data_q(wr_data_q), .beat_col_q(beat_col_q), .ref_row_q(ref_row_q));
  sdc_ctrl_model sdc_ctrl_model_i (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));

  task automatic cmp(input logic [31:0] e, input logic [31:0] g, input string k);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s at %0t: exp %h got %h", k, $time, e, g);
    end
  endtask
  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g); cmp(e, g, "register"); endtask
  task automatic chk_lat(input logic [31:0] e, input logic [31:0] g); cmp(e, g, "cycle"); endtask
  task automatic chk_state(input logic [31:0] e, input logic [31:0] g); cmp(e, g, "state"); endtask
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    if (!wr)
      q_reg.push_back(e);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be_w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40)
      err_total++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
    sdc_ctrl_model_i.issue(c, b, a, k);
    c0 = cyc;
  endtask
  task automatic at(input int n);
    while (cyc < n)
      @(negedge clk);
  endtask
  task automatic col_ap(input logic wr, input logic bl8);
    logic [9:0] col;
    int x;
    col = 10'($urandom);
    al = $urandom % 7;
    cl = 3 + $urandom % 3;
    sh = bl8 ? 3 : 2;
    seg = col >> sh;
    bus(1, sdc_pkg::OFS_CFG, 32'h3000 | ($urandom % 2) << 9 | bl8 << 8 | al << 4 | cl, 0);
    cmd(sdc_pkg::CMD_ACT, 3'h5, 14'($urandom), 1);
    // one burst per activate, issued after tRCD
    sdc_ctrl_model_i.idle(12);
    cmd(wr ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD, 3'h5, {3'h0, 1'b1, col}, 1);
    x = wr ? al + cl + 2 + sh * 2 - 2 : al + sh * 2 - 2;
    q_int.push_back(c0 + al + 2);
    q_col.push_back(col);
    q_dat.push_back(c0 + al + cl + 2 - wr);
    fork
      sdc_ctrl_model_i.idle(40);
      begin
        at(c0 + x);
        chk_state(1, bank_open_q[5]);
        at(c0 + x + 1);
        chk_state(0, bank_open_q[5]);
      end
    join
    $display("done: column access wr=%0d bl8=%0d al=%0d cl=%0d", wr, bl8, al, cl);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      end_sim();
    end
  end
  // an issue or data window with no note queued compares against unknown
  always @(negedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk_reg(pop(q_reg), avs_readdata);
    if ((int_rd_q | int_wr_q) === 1'b1 && !p_int) begin
      chk_lat(pop(q_int), cyc);
      chk_state(pop(q_col), int_col_q);
    end
    if ((rd_data_q | wr_data_q) === 1'b1) begin
      if (!p_dat)
        chk_lat(pop(q_dat), cyc);
      chk_state(seg, beat_col_q >> sh);
    end
    p_int = int_rd_q | int_wr_q;
    p_dat = rd_data_q | wr_data_q;
  end

  initial begin
    {cyc, err_total, n_compared, nref, sh, p_int, p_dat} = '0;
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    ce = 1'b1;
    avs_byteenable = 4'hf;
    be_w = 4'hf;
    seg = '0;
    void'($urandom(32'hbd40));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(0, sdc_pkg::OFS_CFG, 0, 32'h3003);
    bus(0, sdc_pkg::OFS_STATUS, 0, 32'h600);
    bus(0, 4'h2, 0, 0);
    bus(1, sdc_pkg::OFS_CFG, 32'h3073, 0);
    bus(0, sdc_pkg::OFS_CFG, 0, 32'h3063);
    // only byte 1 enabled: burst, order and recovery change, latencies stay
    be_w = 4'h2;
    bus(1, sdc_pkg::OFS_CFG, 32'h5377, 0);
    be_w = 4'hf;
    bus(0, sdc_pkg::OFS_CFG, 0, 32'h5363);
    $display("done: registers");
    for (int i = 0; i < 4; i++)
      col_ap(i[0], i[1]);
    for (int b = 0; b < 8; b += 3)
      cmd(sdc_pkg::CMD_ACT, 3'(b), 14'($urandom), 1);
    sdc_ctrl_model_i.idle(2);
    chk_state(8'h49, bank_open_q);
    cmd(sdc_pkg::CMD_PRE, 3'($urandom), 14'h400, 1);
    sdc_ctrl_model_i.idle(2);
    chk_state(0, bank_open_q);
    $display("done: precharge all");
    // refreshes spaced well inside the limits
    repeat (3) begin
      cmd(sdc_pkg::CMD_ACT, 3'h1, 14'($urandom), 1);
      sdc_ctrl_model_i.idle(12);
      cmd(sdc_pkg::CMD_REF, 3'($urandom), 14'($urandom), 1);
      nref++;
      sdc_ctrl_model_i.idle(30);
      chk_state(nref, ref_row_q);
      chk_state(0, bank_open_q);
    end
    bus(0, sdc_pkg::OFS_REFCNT, 0, nref);
    $display("done: refresh");
    // no termination pin; clock kept running
    cmd(sdc_pkg::CMD_REF, 3'h0, 14'h0, 0);
    sdc_ctrl_model_i.idle(2);
    chk_state(3'b100, {self_refresh_q, dll_on_q, clk_run_q});
    cmd(sdc_pkg::CMD_ACT, 3'h2, 14'h0, 0);
    // long enough for one internally timed refresh
    sdc_ctrl_model_i.idle(1600);
    chk_state(0, bank_open_q);
    chk_state(nref + 1, ref_row_q);
    chk_state(1, self_refresh_q);
    sdc_ctrl_model_i.cke_v = 1'b1;
    // exit by deselect, then quiet interval
    sdc_ctrl_model_i.idle(40);
    chk_state(3'b011, {self_refresh_q, dll_on_q, clk_run_q});
    cmd(sdc_pkg::CMD_REF, 3'h0, 14'h0, 1);
    sdc_ctrl_model_i.idle(30);
    $display("done: self refresh");
    cmd(sdc_pkg::CMD_ACT, 3'h4, 14'($urandom), 1);
    cmd(sdc_pkg::CMD_NOP, 3'h4, 14'h400, 1);
    cmd(sdc_pkg::CMD_UND, 3'h4, 14'h400, 1);
    cmd(sdc_pkg::CMD_MRS, 3'h4, 14'h400, 1);
    sdc_ctrl_model_i.idle(40);
    chk_state(8'h10, bank_open_q);
    // clock enable low freezes decode, so this activate is lost
    ce <= 1'b0;
    cmd(sdc_pkg::CMD_ACT, 3'h7, 14'($urandom), 1);
    ce <= 1'b1;
    sdc_ctrl_model_i.idle(4);
    chk_state(8'h10, bank_open_q);
    $display("done: no-operation codes");
    end_sim();
  end
endmodule // test_sdc_top
